// file: inc/se_pkg.sv
// Shared constants for the two-wire serial memory slave front end.
// Assumes a 250 MHz system clock and a bus master that drives the serial clock.
package se_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 4;
  // Longest self-timed programming time, one row
  localparam int PROGRAM_CYCLE_TIME_NS = 10_000_000;
  // Longest time rounds down to whole clock cycles
  localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W     = 24;

  // ------------------------------------------------------------
  // Serial framing and memory geometry
  // ------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] NBYTES_MAX    = 4'hF;
  localparam int         ADDR_W        = 7;
  localparam int         MEM_DEPTH     = 128;
  localparam int         ROW_BYTES     = 8;
  // Device type code; value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6;

  // ------------------------------------------------------------
  // Byte phases within one exchange
  // ------------------------------------------------------------
  localparam logic [1:0] PH_SEL  = 2'h0;
  localparam logic [1:0] PH_ADDR = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;

  // ------------------------------------------------------------
  // Controller states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SHIFT = 4'h2,
    ST_ACK   = 4'h4,
    ST_PROG  = 4'h8
  } se_state_t;

endpackage

// file: verilog/se_i2c_slave.sv
// Write-path front end of a 128 x 8 serial memory on a two-wire bus.
// Assumes an open-drain data wire resolved outside and a master-driven
// serial clock that runs only during frames.
`timescale 1ns/100ps
`default_nettype none

module se_i2c_slave
  import se_pkg::*;
#(
  parameter int         PROG_CYCLES_P = se_pkg::PROG_CYCLES,
  parameter bit         WP_VARIANT    = 1'b0,
  parameter logic [3:0] DEV_TYPE      = se_pkg::DEV_TYPE_DEFAULT
) (
  // System clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Serial link
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Straps and control pins
  input  wire logic [2:0] chip_select_straps,
  input  wire logic       mode_multibyte,
  input  wire logic       write_protect_input,
  // Memory inspection and status
  input  wire logic [6:0] mem_rd_addr,
  output logic      [7:0] mem_rd_data,
  output logic            prog_busy
);
  import se_pkg::*;

  // ------------------------------------------------------------
  // State types
  // ------------------------------------------------------------
  // Link-side state: the last captured data bit and a toggle that
  // flips once per rising serial clock edge
  typedef struct packed {
    logic bit_q;
    logic tog;
  } se_link_t;

  // System-side state: synchronisers, controller, write latches and
  // the programming timer. The latches hold one row, so a page write
  // never needs more than eight entries
  typedef struct packed {
    logic                  scl_s1;
    logic                  scl_s2;
    logic                  scl_q;
    logic                  sda_s1;
    logic                  sda_s2;
    logic                  sda_q;
    logic                  tog_s1;
    logic                  tog_s2;
    logic                  tog_q;
    logic [2:0]            cs_s1;
    logic [2:0]            cs_s2;
    logic                  md_s1;
    logic                  md_s2;
    logic                  wp_s1;
    logic                  wp_s2;
    se_state_t             state;
    logic [1:0]            phase;
    logic [3:0]            cnt;
    logic [7:0]            shreg;
    logic                  wr_cmd;
    logic                  drive;
    logic                  wp_seen;
    logic                  mb_mode;
    logic [6:0]            addr;
    logic [3:0]            first_row;
    logic [3:0]            last_row;
    logic [3:0]            nbytes;
    logic [7:0]            valid;
    logic [7:0][7:0]       ld;
    logic [7:0][6:0]       la;
    logic [TIMER_W-1:0]    timer;
    logic [7:0]            rd_data;
  } se_sys_t;

  // Timer reloads. The timer counts down to zero, so the busy time is
  // the reload plus one cycle; the double value covers a multibyte
  // write whose bytes span two rows
  localparam logic [TIMER_W-1:0] T_ONE = TIMER_W'(PROG_CYCLES_P - 1);
  localparam logic [TIMER_W-1:0] T_TWO = TIMER_W'(2 * PROG_CYCLES_P - 1);

  se_link_t link;
  se_link_t next_link;
  se_sys_t  r;
  se_sys_t  next_r;
  logic [7:0] mem [MEM_DEPTH];

  // Decoded bus events and the latch slot for the current data byte
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       sel_match;
  logic [2:0] idx;

  // ------------------------------------------------------------
  // Link clock domain
  // ------------------------------------------------------------
  // capture on rise
  always_comb begin
    next_link       = link;
    next_link.bit_q = sda_in;
    next_link.tog   = ~link.tog;
  end

  // Only a held bit and an edge toggle cross; the bit is stable long
  // before the synchronised toggle is seen
  // The link flops share the system reset; the serial clock stands
  // high between frames, so releasing reset never meets a link edge
  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // ------------------------------------------------------------
  // Bus event decode
  // ------------------------------------------------------------
  // Events are taken from second and third synchroniser stages only
  // A rise event is one system cycle wide; the captured bit is read
  // in that cycle, long after it settled in the link domain
  assign rise = r.tog_s2 != r.tog_q;
  assign fall = r.scl_q & ~r.scl_s2;
  assign start = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
  assign stop  = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;
  assign sel_match = (r.shreg[7:4] == DEV_TYPE) && (r.shreg[3:1] == r.cs_s2);
  assign idx = r.mb_mode ? r.nbytes[2:0] : r.addr[2:0];

  // ------------------------------------------------------------
  // Controller next state
  // ------------------------------------------------------------
  // All synchronisers advance every cycle; the controller below reacts
  // to decoded events and synchronised levels, never to the raw pins
  always_comb begin
    next_r        = r;
    next_r.scl_s1 = scl_clk;
    next_r.scl_s2 = r.scl_s1;
    next_r.scl_q  = r.scl_s2;
    next_r.sda_s1 = sda_in;
    next_r.sda_s2 = r.sda_s1;
    next_r.sda_q  = r.sda_s2;
    next_r.tog_s1 = link.tog;
    next_r.tog_s2 = r.tog_s1;
    next_r.tog_q  = r.tog_s2;
    next_r.cs_s1  = chip_select_straps;
    next_r.cs_s2  = r.cs_s1;
    next_r.md_s1  = mode_multibyte;
    next_r.md_s2  = r.md_s1;
    next_r.wp_s1  = write_protect_input;
    next_r.wp_s2  = r.wp_s1;
    next_r.rd_data = mem[mem_rd_addr];

    // The protect level is gathered from START through the address
    // byte; once data bytes begin, a late change has no effect
    // protect window
    if ((r.state == ST_SHIFT || r.state == ST_ACK) && r.phase != PH_DATA) begin
      next_r.wp_seen = r.wp_seen | (r.wp_s2 & WP_VARIANT);
    end

    unique case (r.state)
      ST_IDLE: begin
        next_r.drive = 1'b0;
      end
      ST_SHIFT: begin
        if (rise) begin
          next_r.shreg = {r.shreg[6:0], link.bit_q};
          next_r.cnt   = r.cnt + 4'h1;
        end else if (fall && r.cnt == BITS_PER_BYTE) begin
          // Unanswered bytes park the controller until the next START
          next_r.cnt   = 4'h0;
          next_r.state = ST_IDLE;
          if (r.phase == PH_SEL) begin
            if (sel_match) begin
              next_r.drive  = 1'b1;
              next_r.state  = ST_ACK;
              next_r.wr_cmd = ~r.shreg[0];
              next_r.phase  = PH_ADDR;
            end
          end else if (r.phase == PH_ADDR) begin
            next_r.addr      = r.shreg[6:0];
            next_r.first_row = r.shreg[6:3];
            next_r.mb_mode   = r.md_s2 & ~WP_VARIANT;
            next_r.drive     = 1'b1;
            next_r.state     = ST_ACK;
            next_r.phase     = PH_DATA;
          end else if (!r.wp_seen) begin
            next_r.ld[idx]    = r.shreg;
            next_r.la[idx]    = r.addr;
            next_r.valid[idx] = 1'b1;
            next_r.last_row   = r.addr[6:3];
            // Count saturates; STOP only needs to know that work is pending
            if (r.nbytes != NBYTES_MAX) begin
              next_r.nbytes = r.nbytes + 4'h1;
            end
            if (r.mb_mode) begin
              next_r.addr = r.addr + 7'h01;
            end else begin
              next_r.addr = {r.addr[6:3], r.addr[2:0] + 3'h1};
            end
            next_r.drive = 1'b1;
            next_r.state = ST_ACK;
          end
        end
      end
      ST_ACK: begin
        if (fall) begin
          next_r.drive = 1'b0;
          next_r.state = r.wr_cmd ? ST_SHIFT : ST_IDLE;
        end
      end
      ST_PROG: begin
        // Bus is ignored until the cycle ends
        if (r.timer == '0) begin
          next_r.state  = ST_IDLE;
          next_r.valid  = 8'h00;
          next_r.nbytes = 4'h0;
        end else begin
          next_r.timer = r.timer - TIMER_W'(1);
        end
      end
      default: begin
        next_r.state = ST_IDLE;
        next_r.drive = 1'b0;
      end
    endcase

    // START and STOP override the byte handling above; a START in mid
    // frame drops any latched bytes, as the master has abandoned them
    // start watch
    if (r.state != ST_PROG) begin
      if (start) begin
        next_r.state   = ST_SHIFT;
        next_r.phase   = PH_SEL;
        next_r.cnt     = 4'h0;
        next_r.drive   = 1'b0;
        next_r.wr_cmd  = 1'b0;
        next_r.wp_seen = r.wp_s2 & WP_VARIANT;
        next_r.nbytes  = 4'h0;
        next_r.valid   = 8'h00;
      end else if (stop) begin
        next_r.drive  = 1'b0;
        next_r.wr_cmd = 1'b0;
        next_r.state  = ST_IDLE;
        if (r.wr_cmd && r.nbytes != 4'h0) begin
          next_r.state = ST_PROG;
          next_r.timer = (r.mb_mode && r.first_row != r.last_row) ? T_TWO : T_ONE;
        end
      end
    end
  end

  // The clock and data synchronisers reset to the idle bus level so that no false START
  // or serial clock edge follows reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r       <= '0;
      r.state <= ST_IDLE;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_q  <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_q  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Memory array
  // ------------------------------------------------------------
  // Latched bytes land together at the end of the cycle, so a cycle
  // cut short by reset leaves the array untouched
  // Limitation: the array has no reset and reads unknown until a
  // location is first written
  always_ff @(posedge clk_sys) begin
    if (r.state == ST_PROG && r.timer == '0) begin
      for (int i = 0; i < ROW_BYTES; i++) begin
        if (r.valid[i]) begin
          mem[r.la[i]] <= r.ld[i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // The data pin is never driven high; the enable alone carries the
  // acknowledge, so the wired bus cannot see contention
  // open drain low
  assign sda_out     = 1'b0;
  assign sda_oe_n    = ~r.drive;
  assign mem_rd_data = r.rd_data;
  assign prog_busy   = (r.state == ST_PROG);

endmodule

`default_nettype wire

// file: verification/se_i2c_monitor.sv
// Port checker for the serial memory slave.
// Assumes it is bound to every slave instance.
`timescale 1ns/100ps
`default_nettype none
module se_i2c_monitor #(
  parameter int PROG_CYCLES_P = 20
) (
  // Clock, reset and link
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Status
  input wire logic prog_busy
);
  int unsigned cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Busy length, so the timer can be judged in whole cycles
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
    end else begin
      cnt <= prog_busy ? cnt + 1 : 0;
    end
  end
  sequence s_start;
    scl_clk && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_clk && $rose(sda_in);
  endsequence
  chk_drive_low: assert property (sda_out == 1'b0)
    else $error("data driven high");
  chk_ack_clk_low: assert property ($fell(sda_oe_n) |-> !scl_clk)
    else $error("ack began with clock high");
  chk_rel_clk_low: assert property ($rose(sda_oe_n) |-> !scl_clk)
    else $error("ack ended with clock high");
  chk_ack_bounded: assert property ($fell(sda_oe_n) |-> ##[1:300] sda_oe_n)
    else $error("ack held too long");
  chk_start_quiet: assert property (s_start |-> sda_oe_n [*8])
    else $error("ack right after start");
  chk_stop_quiet: assert property (s_stop |-> ##1 sda_oe_n [*4])
    else $error("ack right after stop");
  chk_busy_quiet: assert property (prog_busy |-> sda_oe_n)
    else $error("ack while programming");
  chk_busy_len: assert property ($fell(prog_busy) |->
    cnt >= PROG_CYCLES_P && cnt <= 2 * PROG_CYCLES_P + 4)
    else $error("programming time wrong");
  chk_prog_idle: assert property ($rose(prog_busy) |-> sda_in && scl_clk)
    else $error("programming began off a stop");
endmodule
`default_nettype wire

// file: verification/se_mst.sv
// Bus master model: makes the serial clock and drives data.
// Assumes the bench resolves the open-drain wire into sda.
`timescale 1ns/100ps
`default_nettype none
module se_mst (
  // Wire levels
  input  wire logic sda,
  output logic      scl_clk,
  output logic      sda_m
);
  logic lclk;
  // 32 ns base, phase unrelated to the system clock
  initial begin
    lclk = 1'b0;
    scl_clk = 1'b1;
    sda_m = 1'b1;
    #7;
    forever #16 lclk = ~lclk;
  end
  task automatic q(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // data moves only with clock low
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    q(2);
    scl_clk = 1'b1;
    q(1);
    r = sda;
    q(1);
    scl_clk = 1'b0;
    q(1);
  endtask
  task automatic start();
    sda_m = 1'b1;
    q(1);
    scl_clk = 1'b1;
    q(2);
    sda_m = 1'b0;
    q(2);
    scl_clk = 1'b0;
    q(1);
  endtask
  // data rises with clock high; clock then stands high
  task automatic stop();
    sda_m = 1'b0;
    q(2);
    scl_clk = 1'b1;
    q(2);
    sda_m = 1'b1;
    q(2);
  endtask
  // MSB first; release for the ninth pulse
  task automatic send(input logic [7:0] b, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    a = ~r;
  endtask
endmodule
`default_nettype wire

// file: verification/se_i2c_slave_tb.sv
// Bench: standard and protect variants share one two-wire bus.
// Assumes se_pkg is compiled first.
`timescale 1ns/100ps
`default_nettype none
module se_i2c_slave_tb;
  import se_pkg::*;
  // Long enough that a START can land inside a programming cycle
  localparam int P = 100;
  logic clk_sys, nrst, scl_clk, sda_m, sda, mode, wp, o0, n0, o1, n1, busy0, busy1, res_vld;
  logic [6:0] ra;
  logic [7:0] rd0, rd1;
  logic [15:0] res_val;
  logic [15:0] exp_q[$];
  logic [31:0] rs = 32'h53C9DDAB;
  int error_cnt = 0, samples_checked = 0, bc = 0;
  // Open-drain wire with pull-up
  assign sda = sda_m & (n0 | o0) & (n1 | o1);
  se_mst u_se_mst (.sda(sda), .scl_clk(scl_clk), .sda_m(sda_m));
  se_i2c_slave #(.PROG_CYCLES_P(P)) u_se_i2c_slave (.clk_sys(clk_sys), .nrst(nrst),
    .scl_clk(scl_clk), .sda_in(sda), .sda_out(o0), .sda_oe_n(n0),
    .chip_select_straps(3'h5), .mode_multibyte(mode), .write_protect_input(wp),
    .mem_rd_addr(ra), .mem_rd_data(rd0), .prog_busy(busy0));
  se_i2c_slave #(.PROG_CYCLES_P(P), .WP_VARIANT(1'b1)) u_se_i2c_slave_wp (.clk_sys(clk_sys),
    .nrst(nrst), .scl_clk(scl_clk), .sda_in(sda), .sda_out(o1), .sda_oe_n(n1),
    .chip_select_straps(3'h2), .mode_multibyte(mode), .write_protect_input(wp),
    .mem_rd_addr(ra), .mem_rd_data(rd1), .prog_busy(busy1));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Busy cycles, cleared by the main sequence
  always @(posedge clk_sys) bc <= (busy0 | busy1) ? bc + 1 : bc;
  // Result watcher takes the oldest note
  always @(posedge clk_sys) begin
    if (res_vld === 1'b1) begin
      samples_checked++;
      if (exp_q.size() == 0 || res_val !== exp_q[0]) begin
        error_cnt++;
        $display("mismatch t=%0t got=%h exp=%h", $time, res_val, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic ck(input logic [15:0] e, input logic [15:0] v);
    exp_q.push_back(e);
    @(negedge clk_sys);
    res_val <= v;
    res_vld <= 1'b1;
    @(negedge clk_sys);
    res_vld <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] b[$], output logic [15:0] ak);
    logic a;
    ak = '0;
    u_se_mst.start();
    foreach (b[i]) begin
      u_se_mst.send(b[i], a);
      ak[i] = a;
    end
    u_se_mst.stop();
  endtask
  task automatic rdm(input bit dv, input logic [6:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    ra = a;
    repeat (2) @(negedge clk_sys);
    ck({8'h00, e}, {8'h00, dv ? rd1 : rd0});
  endtask
  task automatic settle();
    repeat (3 * P + 40) @(negedge clk_sys);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #300000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] ak;
    logic [7:0] d[9];
    logic [7:0] b[$];
    nrst = 0;
    mode = 0;
    wp = 0;
    ra = 0;
    res_vld = 0;
    res_val = 0;
    repeat (2) @(negedge clk_sys);
    nrst = 1;
    repeat (4) @(negedge clk_sys);
    ck(16'h000C, {12'h0, n0, n1, busy0, busy1});
    foreach (d[i]) begin
      rs = xs(rs);
      d[i] = rs[7:0];
    end
    xfer('{8'h9A}, ak);
    ck(16'h0, ak);
    xfer('{8'h6E}, ak);
    ck(16'h0, ak);
    bc = 0;
    xfer('{8'h6B}, ak);
    settle();
    ck(16'h0001, ak);
    ck(16'h0, bc[15:0]);
    // Byte write, top address bit set; a select during programming is ignored
    xfer('{8'h6A, {1'b1, rs[14:8]}, d[0]}, ak);
    ck(16'h0007, ak);
    xfer('{8'h6A}, ak);
    ck(16'h0, ak);
    settle();
    rdm(0, rs[14:8], d[0]);
    // Page write of nine bytes from slot 6 wraps and overwrites
    b = '{8'h6A, 8'h0E};
    foreach (d[i]) b.push_back(d[i]);
    xfer(b, ak);
    ck(16'h07FF, ak);
    settle();
    for (int i = 1; i < 9; i++) rdm(0, 7'h08 + 7'((6 + i) % 8), d[i]);
    // Multibyte across two rows doubles the time
    @(negedge clk_sys);
    mode = 1;
    bc = 0;
    xfer('{8'h6A, 8'h1E, d[3], d[4], d[5]}, ak);
    ck(16'h001F, ak);
    settle();
    ck(16'(2 * P), bc[15:0]);
    for (int i = 0; i < 3; i++) rdm(0, 7'h1E + 7'(i), d[3 + i]);
    // Protect variant: open write, then a protected one
    // A row-end pair with mode high wraps to slot 0: no multibyte mode
    xfer('{8'h64, 8'h07, d[1], d[2]}, ak);
    ck(16'h000F, ak);
    settle();
    rdm(1, 7'h00, d[2]);
    @(negedge clk_sys);
    wp = 1;
    bc = 0;
    xfer('{8'h64, 8'h07, ~d[1]}, ak);
    ck(16'h0003, ak);
    settle();
    ck(16'h0, bc[15:0]);
    rdm(1, 7'h07, d[1]);
    tally_and_finish();
  end
endmodule
bind se_i2c_slave se_i2c_monitor #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_mon (.clk_sys(clk_sys),
  .nrst(nrst), .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .prog_busy(prog_busy));
`default_nettype wire
